/* File: core/stw_host.v */
// Purpose: AHB-Lite controlled sender of 38-bit serial trim words
// Assumes: single word transfers, OKAY response, one slave on the bus
// Notes:   keeps a shadow of the simulation codes and master fuse the device should hold
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "stw_regs.vh"
module stw_host (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        resetn_i,
  // AHB-Lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  // Serial trim wire
  output reg         trim_pin_o,
  // Shadowed simulation codes, forced to zero once the master fuse is blown
  output reg  [2:0]  gain2_code_o,
  output reg  [6:0]  gain1_code_o,
  output reg  [7:0]  offset_code_o
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  reg rst_s1_q;                      // First sync stage
  reg rst_n_q;                       // Released reset
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Word assembly, start field lands in top bits
  function [37:0] build_word;
    input [1:0] fn;
    input [1:0] par;
    input [7:0] val;
    begin
      // Fixed frame and fields, sent MSB first
      build_word = {`STW_SOP, fn, par, `STW_DUMMY, val, `STW_EOP};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  localparam [2:0] ST_IDLE = 3'h1;   // Idle
  localparam [2:0] ST_SEND = 3'h2;   // Feeding bits
  localparam [2:0] ST_WAIT = 3'h4;   // Last pulse finishing

  // Bit count at counter width
  localparam [5:0] WORD_LEN = `STW_WORD_BITS;  // Bits in one word

  reg [2:0]  state_q;                // One-hot sender state
  reg [37:0] shift_q;                // Outgoing word
  reg [5:0]  left_q;                 // Bits still to send
  reg [17:0] cmd_q;                  // fn[17:16] par[15:14] val[7:0]
  reg        done_q;                 // Word sent, sticky
  reg        badsel_q;               // Simulate with selector 11
  reg        master_q;               // Master fuse blown per shadow
  reg [2:0]  sim2_q;                 // Shadow simulation codes
  reg [6:0]  sim1_q;
  reg [7:0]  simo_q;
  reg        go_pulse;               // Start request from bus
  reg        load_q;                 // Bit request to pulse shaper
  wire       pg_ready;               // Pulse shaper ready
  wire       pg_pin;                 // Pulse shaper wire

  // AHB address phase capture
  reg        aph_q;                  // Pending data phase
  reg        awr_q;                  // Pending write
  reg [7:0]  aaddr_q;                // Pending offset

  wire busy = (state_q != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Bus address phase, zero wait states
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aph_q   <= 1'b0;
      awr_q   <= 1'b0;
      aaddr_q <= 8'h00;
    end else if (hready_i) begin
      aph_q   <= hsel_i & htrans_i[1];
      awr_q   <= hwrite_i;
      aaddr_q <= haddr_i[7:0];
    end
  end

  // Write data phase, go pulse and command store
  always @* begin
    go_pulse = aph_q & awr_q & (aaddr_q == `STW_A_CTRL) &
               hwdata_i[`STW_CTRL_GO] & ~busy;
  end

  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmd_q       <= 18'h0_0000;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      if (aph_q & awr_q & (aaddr_q == `STW_A_CMD) & ~busy)
        cmd_q <= {hwdata_i[17:16], hwdata_i[15:14], 6'h00, hwdata_i[7:0]};
      // Read data registered for next phase
      if (hready_i & hsel_i & htrans_i[1] & ~hwrite_i) begin
        case (haddr_i[7:0])
          `STW_A_CTRL: hrdata_o <= 32'h0000_0000;
          `STW_A_CMD:  hrdata_o <= {14'h0000, cmd_q};
          `STW_A_STAT: hrdata_o <= {29'h0000_0000, badsel_q, done_q, busy};
          `STW_A_SHADOW:
            hrdata_o <= {7'h00, master_q, simo_q, 1'b0, sim1_q, 5'h00,
                         sim2_q};
          default:     hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sender state machine
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q  <= ST_IDLE;
      shift_q  <= 38'h00_0000_0000;
      left_q   <= 6'h00;
      load_q   <= 1'b0;
      done_q   <= 1'b0;
      badsel_q <= 1'b0;
    end else begin
      load_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (go_pulse) begin
            shift_q  <= build_word(cmd_q[17:16], cmd_q[15:14], cmd_q[7:0]);
            left_q   <= WORD_LEN;
            done_q   <= 1'b0;
            // Selector 11 with simulate does nothing on device
            badsel_q <= (cmd_q[17:16] == `STW_FN_SIM) &
                        (cmd_q[15:14] == `STW_PAR_OTHER);
            state_q  <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (load_q) begin
            // Shift only after the shaper has taken the top bit
            shift_q <= {shift_q[36:0], 1'b0};
          end else if (pg_ready) begin
            // MSB first, start field first
            load_q  <= 1'b1;
            left_q  <= left_q - 6'h01;
            if (left_q == 6'h01)
              state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (pg_ready & ~load_q) begin
            done_q  <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  stw_pulse_gen u_pulse (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_q),
    .load_i  (load_q),
    .bit_i   (shift_q[37]),
    .ready_o (pg_ready),
    .pin_o   (pg_pin)
  );

  ////////////////////////////////////////////////////////////////////////
  // Shadow of device parameter state, updated when word completes
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // Power-on state all zero
      sim2_q   <= 3'h0;
      sim1_q   <= 7'h00;
      simo_q   <= 8'h00;
      master_q <= 1'b0;
    end else if (state_q == ST_WAIT && pg_ready && !load_q) begin
      // Simulate loads only the chosen target
      if (cmd_q[17:16] == `STW_FN_SIM && !master_q) begin
        case (cmd_q[15:14])
          `STW_PAR_GAIN2:  sim2_q <= cmd_q[2:0];
          `STW_PAR_GAIN1:  sim1_q <= cmd_q[6:0];
          `STW_PAR_OFFSET: simo_q <= cmd_q[7:0];
          default:         sim2_q <= sim2_q;
        endcase
      end
      // Master fuse is value bit 0 of other functions
      if (cmd_q[17:16] == `STW_FN_PROG &&
          cmd_q[15:14] == `STW_PAR_OTHER && cmd_q[0])
        master_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      trim_pin_o    <= 1'b0;
      gain2_code_o  <= 3'h0;
      gain1_code_o  <= 7'h00;
      offset_code_o <= 8'h00;
    end else begin
      trim_pin_o <= pg_pin;
      // Simulated codes count only while master intact
      gain2_code_o  <= master_q ? 3'h0  : sim2_q;
      gain1_code_o  <= master_q ? 7'h00 : sim1_q;
      offset_code_o <= master_q ? 8'h00 : simo_q;
    end
  end

endmodule
`default_nettype wire

/* File: core/stw_regs.vh */
// Purpose: constants for the serial trim word controller
// Assumes: 40 MHz reference clock, 32-bit AHB-Lite register words
// Notes:   word framing, command fields, pulse timing and register map
`ifndef STW_REGS_VH
`define STW_REGS_VH

// Word framing
`define STW_WORD_BITS     38
`define STW_SOP           12'h801
`define STW_DUMMY         2'h2
`define STW_EOP           12'h7FE

// Function codes
`define STW_FN_SENSE      2'h0
`define STW_FN_SIM        2'h1
`define STW_FN_PROG       2'h2
`define STW_FN_READ       2'h3

// Parameter selectors
`define STW_PAR_GAIN2     2'h0
`define STW_PAR_GAIN1     2'h1
`define STW_PAR_OFFSET    2'h2
`define STW_PAR_OTHER     2'h3

// Timing in ns and clock figures
`define STW_CLK_NS        25
`define STW_T0_NS         1000
`define STW_T1_NS         50000
`define STW_TGAP_NS       10000
`define STW_T0_CYC        ((`STW_T0_NS + `STW_CLK_NS - 1) / `STW_CLK_NS)
`define STW_T1_CYC        ((`STW_T1_NS + `STW_CLK_NS - 1) / `STW_CLK_NS)
`define STW_TGAP_CYC      ((`STW_TGAP_NS + `STW_CLK_NS - 1) / `STW_CLK_NS)

// Register byte offsets
`define STW_A_CTRL        8'h00
`define STW_A_CMD         8'h04
`define STW_A_STAT        8'h08
`define STW_A_SHADOW      8'h0C

// Control and status fields
`define STW_CTRL_GO       0
`define STW_STAT_BUSY     0
`define STW_STAT_DONE     1
`define STW_STAT_BADSEL   2

`endif

/* File: core/stw_pulse_gen.v */
// Purpose: shapes one bit into one pulse on the serial trim wire
// Assumes: load only while ready is high
// Notes:   pulse width carries the bit, then a low gap follows
`timescale 1ns/1ps
`default_nettype none
`include "stw_regs.vh"
module stw_pulse_gen (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Bit request
  input  wire        load_i,
  input  wire        bit_i,
  output reg         ready_o,
  // Wire
  output reg         pin_o
);

  ////////////////////////////////////////////////////////////////////////
  localparam [2:0] ST_IDLE = 3'h1;   // Waiting for a bit
  localparam [2:0] ST_HIGH = 3'h2;   // Pulse high
  localparam [2:0] ST_GAP  = 3'h4;   // Gap low

  // Counter loads at counter width, each one cycle short of the span
  localparam [15:0] LD_ONE  = `STW_T1_CYC - 1;    // High span of a one
  localparam [15:0] LD_ZERO = `STW_T0_CYC - 1;    // High span of a zero
  localparam [15:0] LD_GAP  = `STW_TGAP_CYC - 1;  // Low span after a pulse

  reg [2:0]  state_q;                // One-hot state
  reg [15:0] cnt_q;                  // Cycle counter

  ////////////////////////////////////////////////////////////////////////
  // Pulse width and gap sequencing
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= 16'h0000;
      ready_o <= 1'b1;
      pin_o   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (load_i) begin
            // Width chosen by the bit value
            cnt_q   <= bit_i ? LD_ONE : LD_ZERO;
            pin_o   <= 1'b1;
            ready_o <= 1'b0;
            state_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (cnt_q == 16'h0000) begin
            // Low gap before next pulse
            pin_o   <= 1'b0;
            cnt_q   <= LD_GAP;
            state_q <= ST_GAP;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        ST_GAP: begin
          if (cnt_q == 16'h0000) begin
            ready_o <= 1'b1;
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          pin_o   <= 1'b0;
          ready_o <= 1'b1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: sim/stw_host_assertions.sv */
// Purpose: protocol checks on the serial trim wire
// Assumes: one word at a time, 40 MHz clock
// Notes:   pulse widths are counted in clock cycles
`timescale 1ns/1ps
`default_nettype none
module stw_host_chk (
  // Clock, reset and wire
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic trim_pin_o
);
  logic [11:0] hi_q;  // High run length
  logic [11:0] lo_q;  // Low run length, saturating
  logic [5:0]  idx_q; // Bit position in word
  logic [37:0] sr_q;  // Bits seen so far
  logic        p_q;   // Wire one cycle ago
  wire         fall = p_q && !trim_pin_o;
  wire  [37:0] nx   = {sr_q[36:0], hi_q >= 12'h190};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  //////////////////////////////////////////////////////////////////////
  // Run lengths and word assembly
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {p_q, hi_q, idx_q, sr_q} <= '0;
      lo_q <= 12'hFFF;
    end else begin
      p_q  <= trim_pin_o;
      hi_q <= trim_pin_o ? hi_q + 12'h001 : 12'h000;
      lo_q <= trim_pin_o ? 12'h000 : (&lo_q ? lo_q : lo_q + 12'h001);
      if (fall) begin
        sr_q  <= nx;
        idx_q <= (idx_q == 6'h25) ? 6'h00 : idx_q + 6'h01;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  a_pulse_min: assert property ($rose(trim_pin_o) |=> trim_pin_o)
    else $error("pulse shorter than two cycles");
  a_pulse_class: assert property (fall |->
    hi_q <= 12'h190 || hi_q >= 12'h7D0)
    else $error("pulse width neither zero nor one");
  a_gap_min: assert property ($rose(trim_pin_o) |-> lo_q >= 12'h190)
    else $error("gap between pulses too short");
  a_start_first: assert property (fall && idx_q == 6'h00 |->
    hi_q >= 12'h7D0)
    else $error("word does not open with start field");
  a_frame_fixed: assert property (fall && idx_q == 6'h25 |->
    nx[37:26] == 12'h801 && nx[21:20] == 2'h2 && nx[11:0] == 12'h7FE)
    else $error("fixed fields of word wrong");
  c_one_bit:  cover property (fall && hi_q >= 12'h7D0);
  c_zero_bit: cover property (fall && hi_q < 12'h190);
  c_word:     cover property (fall && idx_q == 6'h25);
endmodule
bind stw_host stw_host_chk u_chk (
  .ref_clk_i (ref_clk_i),
  .resetn_i  (resetn_i),
  .trim_pin_o(trim_pin_o)
);
`default_nettype wire

/* File: sim/stw_dev_model.sv */
// Purpose: behavioural trim amplifier word decoder
// Assumes: pulse widths measured on the bench clock
// Notes:   read back and sense current are ignored
`timescale 1ns/1ps
`default_nettype none
module stw_dev_model (
  // Clock, reset and wire
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       pin_i,
  // Active codes
  output wire logic [2:0] g2_o,
  output wire logic [6:0] g1_o,
  output wire logic [7:0] off_o,
  output var  logic       mst_o
);
  logic [37:0] sr_q;          // Serial shift register
  logic [15:0] w_q;           // High width counter
  logic        p_q;           // Wire one cycle ago
  logic [2:0]  s2_q, f2_q;    // Simulated and fused gain2
  logic [6:0]  s1_q, f1_q;    // Simulated and fused gain1
  logic [7:0]  so_q, fo_q;    // Simulated and fused offset
  wire  [37:0] nx = {sr_q[36:0], w_q >= 16'h0190};
  wire         ok = nx[37:26] == 12'h801 && nx[21:20] == 2'h2
                 && nx[11:0] == 12'h7FE;
  // Fuses win once the master fuse is blown
  assign g2_o  = mst_o ? f2_q : s2_q;
  assign g1_o  = mst_o ? f1_q : s1_q;
  assign off_o = mst_o ? fo_q : so_q;
  //////////////////////////////////////////////////////////////////////
  // Shift on each pulse end, act on a complete word
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {sr_q, w_q, p_q, mst_o} <= '0;
      {s2_q, s1_q, so_q, f2_q, f1_q, fo_q} <= '0;
    end else begin
      p_q <= pin_i;
      w_q <= pin_i ? w_q + 16'h0001 : 16'h0000;
      if (p_q && !pin_i) begin
        sr_q <= nx;
        if (ok && nx[25:24] == 2'h1) begin
          case (nx[23:22])
            2'h0: s2_q <= nx[14:12];
            2'h1: s1_q <= nx[18:12];
            2'h2: so_q <= nx[19:12];
            default: ;
          endcase
        end else if (ok && nx[25:24] == 2'h2) begin
          case (nx[23:22])
            2'h0: f2_q <= f2_q | nx[14:12];
            2'h1: f1_q <= f1_q | nx[18:12];
            2'h2: fo_q <= fo_q | nx[19:12];
            default: mst_o <= mst_o | nx[12];
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/test_serial_trim_word_decoder.sv */
// Purpose: drives the trim word host over the bus against a device model
// Assumes: zero wait slave, one word in flight
// Notes:   each word takes tens of thousands of cycles
`timescale 1ns/1ps
`default_nettype none
`include "stw_regs.vh"
module test_serial_trim_word_decoder;
  logic        ref_clk_i = 1'b0, resetn_i = 1'b0;
  logic        hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = '0, hwdata_i = '0, r;
  logic [1:0]  htrans_i = 2'h0;
  logic [2:0]  hsize_i  = 3'h2;
  wire  [31:0] hrdata_o;
  wire         hreadyout_o, hresp_o, trim_pin_o, mm;
  wire  [2:0]  g2, m2;
  wire  [6:0]  g1, m1;
  wire  [7:0]  go, mo;
  int          err_total = 0, samples_checked = 0, cyc = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  stw_host dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .trim_pin_o(trim_pin_o),
    .gain2_code_o(g2), .gain1_code_o(g1), .offset_code_o(go));
  stw_dev_model dev_u (.clk_i(ref_clk_i), .rst_n_i(resetn_i),
    .pin_i(trim_pin_o), .g2_o(m2), .g1_o(m1), .off_o(mo), .mst_o(mm));
  //////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 600000) begin
      err_total++;
      print_verdict;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One single AHB-Lite transfer, address then data phase
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    hsel_i <= 1'b1; haddr_i <= {24'h00_0000, a};
    htrans_i <= 2'h2; hwrite_i <= w;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0; hsel_i <= 1'b0; hwdata_i <= d;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask
  // Queue a word, start it, poll until done
  task send(input logic [1:0] f, input logic [1:0] p, input logic [7:0] v);
    xfer(1'b1, `STW_A_CMD, {14'h0000, f, p, 6'h00, v});
    xfer(1'b1, `STW_A_CTRL, 32'h0000_0001);
    do xfer(1'b0, `STW_A_STAT, '0); while (r[0] || !r[1]);
  endtask
  // Design shadow codes then device codes
  task codes(input logic [17:0] ed, input logic [17:0] em);
    chk({14'h0000, go, g1, g2}, {14'h0000, ed});
    chk({14'h0000, mo, m1, m2}, {14'h0000, em});
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    xfer(1'b0, `STW_A_SHADOW, '0); chk(r, '0);
    xfer(1'b0, 8'h10, '0);         chk(r, '0);
    codes('0, '0);
    $display("test reset done");
    send(2'h1, 2'h0, 8'hFF);  codes(18'h0_0007, 18'h0_0007);
    send(2'h1, 2'h1, 8'h8B);  codes(18'h0_005F, 18'h0_005F);
    send(2'h1, 2'h2, 8'h40);  codes(18'h1_005F, 18'h1_005F);
    xfer(1'b0, `STW_A_SHADOW, '0); chk(r, 32'h0040_0B07);
    $display("test simulate done");
    send(2'h1, 2'h3, 8'h01);  codes(18'h1_005F, 18'h1_005F);
    chk({31'h0000_0000, mm}, '0);
    xfer(1'b0, `STW_A_STAT, '0);
    chk(r & 32'h0000_0004, 32'h0000_0004);
    $display("test selector other done");
    send(2'h2, 2'h0, 8'h01);  codes(18'h1_005F, 18'h1_005F);
    send(2'h2, 2'h3, 8'h01);  codes('0, 18'h0_0001);
    chk({31'h0000_0000, mm}, 32'h0000_0001);
    xfer(1'b0, `STW_A_SHADOW, '0);
    chk(r, 32'h0140_0B07);
    $display("test fuse done");
    print_verdict;
  end
endmodule
`default_nettype wire
